// File: src/execution_state_status.sv
// Execution-state status bits: combined field, state flag and fault check.
`timescale 1ns/1ps
`include "exec_state_defines.svh"

// Summary of operation
// - One combined field across bits 26:25, 15:10.
// - Transfer restart state keeps bits 26:25 zero.
// - Transfer restart state keeps bits 11:10 zero.
// - Interrupted multiple transfer records next register index.
// - Return resumes transfer at the recorded register.
// - Track up to four conditional block instructions.
// - Block conditions equal base condition or inverse.
// - State flag is read-only bit 24, resets one.
// - Exchanging branches and pops load flag from target.
// - Exception return restores flag from stacked word.
// - Exception entry loads vector bit 0; reset loads one.
// - Executing with flag clear faults or locks up.
// - Reserved bits read zero, never change.
// - Software reads give zero; writes are ignored.

module execution_state_status #(
  parameter int INDEX_W = `EXEC_INDEX_W
) (
  input  wire logic                     clk,
  input  wire logic                     reset_n,
  input  wire logic                     vector_load,
  input  wire logic                     vector_bit0,
  input  wire logic                     exc_return,
  input  wire logic [`EXEC_WORD_W-1:0]  stacked_word,
  input  wire logic                     branch_exchange,
  input  wire logic                     target_bit0,
  input  wire logic                     transfer_suspend,
  input  wire logic [INDEX_W-1:0]       next_reg_index,
  input  wire logic                     cond_block_start,
  input  wire logic [3:0]               block_first_cond,
  input  wire logic [3:0]               block_mask,
  input  wire logic                     instr_retire,
  input  wire logic                     exec_attempt,
  input  wire logic                     in_fault_handler,
  input  wire logic                     sw_rd_en,
  output logic [`EXEC_WORD_W-1:0]       status_word,
  output logic                          cond_active,
  output logic [3:0]                    cond_code,
  output logic                          resume_valid,
  output logic [INDEX_W-1:0]            resume_index,
  output logic                          fault_pulse,
  output logic                          lockup,
  output logic [`EXEC_WORD_W-1:0]       sw_rd_data
);

  // --------------------------------------------------------------------------
  // Elaboration check
  // --------------------------------------------------------------------------
  // The register index must fill word bits 15:12 exactly.
  if (INDEX_W != `EXEC_INDEX_MSB - `EXEC_INDEX_LSB + 1) begin : g_bad_width
    $error("INDEX_W must be four");
  end

  // --------------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------------
  exec_state_pkg::exec_field_t field_reg;     // Combined execution-state field.
  exec_state_pkg::field_mode_t mode_reg;      // What the field holds.
  logic                        flag_reg;      // Instruction-set state flag.
  logic                        resume_reg;    // Resume request pulse.
  logic [INDEX_W-1:0]          resume_idx_reg; // Register to resume at.
  logic                        fault_reg;     // Fault request pulse.
  logic                        lockup_reg;    // Lockup level.
  logic [`EXEC_WORD_W-1:0]     sw_rd_reg;     // Software read data.

  exec_state_pkg::exec_field_t cond_next;     // Field after one block step.
  exec_state_pkg::exec_field_t stacked_field; // Field held in the stacked word.
  logic [3:0]                  cur_cond;      // Condition of current instruction.

  // Returns what a field value holds: zero is idle, an empty low nibble
  // (word bits 26:25 and 11:10) is transfer restart state, else a block.
  function automatic exec_state_pkg::field_mode_t field_mode(
    input exec_state_pkg::exec_field_t f
  );
    if (f == `EXEC_FIELD_RESET) begin
      field_mode = exec_state_pkg::FIELD_IDLE;
    end else if (f[3:0] == 4'h0) begin
      field_mode = exec_state_pkg::FIELD_TRANSFER;
    end else begin
      field_mode = exec_state_pkg::FIELD_COND;
    end
  endfunction

  // Gathers the split field out of a whole status word.
  assign stacked_field = {stacked_word[`EXEC_LO_MSB:`EXEC_LO_LSB],
                          stacked_word[`EXEC_HI_MSB:`EXEC_HI_LSB]};

  // Block stepping and current condition.
  cond_block_tracker u_tracker (
    .field         (field_reg),
    .next_field    (cond_next),
    .cur_cond      (cur_cond),
    .last_in_block ()
  );

  // --------------------------------------------------------------------------
  // Combined field
  // --------------------------------------------------------------------------
  // Exception entry clears the field after it was stacked; return restores
  // it; a suspended transfer stores its index with the low nibble zero; a
  // block start loads condition and mask; retirement steps the block.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      field_reg <= `EXEC_FIELD_RESET;
      mode_reg  <= exec_state_pkg::FIELD_IDLE;
    end else if (vector_load) begin
      field_reg <= `EXEC_FIELD_RESET;
      mode_reg  <= exec_state_pkg::FIELD_IDLE;
    end else if (exc_return) begin
      field_reg <= stacked_field;
      mode_reg  <= field_mode(stacked_field);
    end else if (transfer_suspend) begin
      field_reg <= {next_reg_index, 4'h0};
      mode_reg  <= exec_state_pkg::FIELD_TRANSFER;
    end else if (cond_block_start && (block_mask != 4'h0)) begin
      field_reg <= {block_first_cond, block_mask};
      mode_reg  <= field_mode({block_first_cond, block_mask});
    end else if (instr_retire) begin
      unique case (mode_reg)
        // Step the block; it ends at zero.
        exec_state_pkg::FIELD_COND: begin
          field_reg <= cond_next;
          mode_reg  <= field_mode(cond_next);
        end
        // The resumed transfer has completed.
        exec_state_pkg::FIELD_TRANSFER: begin
          field_reg <= `EXEC_FIELD_RESET;
          mode_reg  <= exec_state_pkg::FIELD_IDLE;
        end
        // Nothing is held.
        exec_state_pkg::FIELD_IDLE: begin
          field_reg <= `EXEC_FIELD_RESET;
          mode_reg  <= exec_state_pkg::FIELD_IDLE;
        end
        // Code 11 cannot arise; fall back to idle.
        default: begin
          field_reg <= `EXEC_FIELD_RESET;
          mode_reg  <= exec_state_pkg::FIELD_IDLE;
        end
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // Resume request
  // --------------------------------------------------------------------------
  // A return into transfer restart state asks for the transfer to go on at
  // the recorded register rather than at its first one.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      resume_reg     <= 1'b0;
      resume_idx_reg <= '0;
    end else begin
      resume_reg <= exc_return && !vector_load &&
                    (field_mode(stacked_field) == exec_state_pkg::FIELD_TRANSFER);
      if (exc_return && !vector_load) begin
        resume_idx_reg <= stacked_word[`EXEC_INDEX_MSB:`EXEC_INDEX_LSB];
      end
    end
  end

  // --------------------------------------------------------------------------
  // Instruction-set state flag
  // --------------------------------------------------------------------------
  // Vector fetch wins over return, return over an exchanging branch.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      flag_reg <= `EXEC_FLAG_RESET;
    end else if (vector_load) begin
      flag_reg <= vector_bit0;
    end else if (exc_return) begin
      flag_reg <= stacked_word[`EXEC_FLAG_BIT];
    end else if (branch_exchange) begin
      flag_reg <= target_bit0;
    end
  end

  // --------------------------------------------------------------------------
  // Wrong-state fault and lockup
  // --------------------------------------------------------------------------
  // Inside a fault handler a second fault cannot be taken, so the core locks
  // up; lockup holds until reset.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      fault_reg  <= 1'b0;
      lockup_reg <= 1'b0;
    end else begin
      fault_reg <= exec_attempt && !flag_reg && !in_fault_handler;
      if (exec_attempt && !flag_reg && in_fault_handler) begin
        lockup_reg <= 1'b1;
      end
    end
  end

  // --------------------------------------------------------------------------
  // Software view
  // --------------------------------------------------------------------------
  // Software reads of these bits return zero; there is no write path, so
  // software writes have no effect at all.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      sw_rd_reg <= `EXEC_WORD_ZERO;
    end else if (sw_rd_en) begin
      sw_rd_reg <= `EXEC_WORD_ZERO;
    end
  end

  // --------------------------------------------------------------------------
  // Outputs
  // --------------------------------------------------------------------------
  // The word carries flops only; reserved and foreign bits are constant zero.
  assign status_word = {5'h00, field_reg[1:0], flag_reg, 8'h00,
                        field_reg[7:2], 4'h0, 6'h00};
  assign cond_active  = mode_reg[0]; // Only the block code has its low bit set.
  assign cond_code    = field_reg[7:4];
  assign resume_valid = resume_reg;
  assign resume_index = resume_idx_reg;
  assign fault_pulse  = fault_reg;
  assign lockup       = lockup_reg;
  assign sw_rd_data   = sw_rd_reg;

  // --------------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  // A quiet cycle: nothing of higher priority than the event under test.
  sequence s_suspend;
    transfer_suspend && !vector_load && !exc_return;
  endsequence

  sequence s_block_open;
    cond_block_start && !vector_load && !exc_return && !transfer_suspend &&
    (block_mask != 4'h0);
  endsequence

  a_transfer_hi_zero: assert property (
    mode_reg == exec_state_pkg::FIELD_TRANSFER |-> status_word[26:25] == 2'h0)
    else $error("transfer state with bits 26:25 set");
  a_transfer_lo_zero: assert property (
    mode_reg == exec_state_pkg::FIELD_TRANSFER |-> status_word[11:10] == 2'h0)
    else $error("transfer state with bits 11:10 set");
  a_transfer_capture: assert property (
    s_suspend |=> status_word[15:12] == $past(next_reg_index))
    else $error("suspend index not recorded");
  a_resume_index: assert property (
    exc_return && !vector_load && stacked_word[26:25] == 2'h0 &&
    stacked_word[11:10] == 2'h0 && stacked_word[15:12] != 4'h0
    |=> resume_valid && resume_index == $past(stacked_word[15:12]))
    else $error("resume request missing or wrong");
  a_block_open: assert property (
    s_block_open |=> cond_active && cond_code == $past(block_first_cond))
    else $error("conditional block not opened");
  a_block_cond: assert property (
    cond_active && instr_retire && !vector_load && !exc_return &&
    !transfer_suspend && !cond_block_start && field_reg[2:0] != 3'h0
    |=> cond_active && cond_code[3:1] == $past(cond_code[3:1]))
    else $error("block condition left its base");
  a_block_end: assert property (
    cond_active && instr_retire && field_reg[2:0] == 3'h0 && !vector_load &&
    !exc_return && !transfer_suspend && !cond_block_start
    |=> !cond_active && field_reg == 8'h00)
    else $error("block did not close to zero");
  a_flag_vector: assert property (
    vector_load |=> flag_reg == $past(vector_bit0))
    else $error("flag not loaded from vector");
  a_flag_return: assert property (
    exc_return && !vector_load |=> flag_reg == $past(stacked_word[24]))
    else $error("flag not restored on return");
  a_flag_branch: assert property (
    branch_exchange && !vector_load && !exc_return
    |=> flag_reg == $past(target_bit0))
    else $error("flag not taken from branch target");
  a_flag_hold: assert property (
    !vector_load && !exc_return && !branch_exchange |=> $stable(flag_reg))
    else $error("flag changed without a source");
  a_wrong_state: assert property (
    exec_attempt && !flag_reg |=> fault_pulse || lockup)
    else $error("no fault for clear state flag");
  a_reserved_zero: assert property (
    status_word[23:16] == 8'h00 && status_word[9:6] == 4'h0)
    else $error("reserved bits not zero");
  a_sw_read: assert property (
    sw_rd_en |=> sw_rd_data == 32'h00000000)
    else $error("software read not zero");

endmodule

// File: src/exec_state_defines.svh
// Bit positions, reset values and widths of the execution-state status bits.
`ifndef EXEC_STATE_DEFINES_SVH
`define EXEC_STATE_DEFINES_SVH

// ----------------------------------------------------------------------------
// Field positions inside the combined status word
// ----------------------------------------------------------------------------
`define EXEC_HI_MSB        26
`define EXEC_HI_LSB        25
`define EXEC_FLAG_BIT      24
`define EXEC_RSVD_HI_MSB   23
`define EXEC_RSVD_HI_LSB   16
`define EXEC_LO_MSB        15
`define EXEC_LO_LSB        10
`define EXEC_INDEX_MSB     15
`define EXEC_INDEX_LSB     12
`define EXEC_RSVD_LO_MSB   9
`define EXEC_RSVD_LO_LSB   6

// ----------------------------------------------------------------------------
// Widths and reset values
// ----------------------------------------------------------------------------
`define EXEC_WORD_W        32
`define EXEC_INDEX_W       4
`define EXEC_FLAG_RESET    1'b1
`define EXEC_FIELD_RESET   8'h00
`define EXEC_WORD_ZERO     32'h00000000

`endif

// File: src/exec_state_pkg.sv
// Types shared by the execution-state status logic.
package exec_state_pkg;

  // Combined field: [7:2] sit at word bits 15:10, [1:0] at word bits 26:25.
  typedef logic [7:0] exec_field_t;

  // What the combined field currently holds.
  typedef enum logic [1:0] {
    FIELD_IDLE     = 2'b00,
    FIELD_COND     = 2'b01,
    FIELD_TRANSFER = 2'b10
  } field_mode_t;

endpackage

// File: src/cond_block_tracker.sv
// Progress step and current condition of a conditional instruction block.
`timescale 1ns/1ps
`include "exec_state_defines.svh"

module cond_block_tracker (
  input  wire exec_state_pkg::exec_field_t field,
  output exec_state_pkg::exec_field_t      next_field,
  output logic [3:0]                       cur_cond,
  output logic                             last_in_block
);

  // The top four bits are the condition of the instruction now in the block.
  // Its upper three bits are the base condition, so each one equals the base
  // condition or its inverse.
  assign cur_cond = field[7:4];

  // The lowest set bit of the mask marks the end; no bit below bit 3 means
  // the instruction now executing is the last one of the block.
  assign last_in_block = (field[2:0] == 3'h0);

  // Advancing shifts the mask, and the next condition bit, up by one place.
  assign next_field = last_in_block ? `EXEC_FIELD_RESET
                                    : {field[7:5], field[3:0], 1'b0};

endmodule

// File: test/execution_state_status_test.sv
// Self-checking testbench for the execution-state status bits.
`timescale 1ns/1ps

module execution_state_status_test;
  // ---------------------------------------------------------------------------
  // Stimulus rows
  // ---------------------------------------------------------------------------
  // One cycle of strobes beside the field, flag and resume it should leave behind.
  typedef struct {
    logic [5:0]  strb;   // Vector, return, exchange, suspend, block start, retire.
    logic [1:0]  bit0s;  // Vector bit 0, branch target bit 0.
    logic [3:0]  idx;    // Register index or base condition.
    logic [3:0]  mask;   // Block mask.
    logic [31:0] stk;    // Stacked status word.
    logic [7:0]  fld;    // Expected combined field.
    logic        flag;   // Expected state flag.
    logic        res;    // Expected resume pulse.
    logic [3:0]  ridx;   // Expected resume index.
  } row_t;

  // Walks, priorities and refusals; conditions 2,2,3,2 show base and inverse.
  row_t rows [0:25] = '{
    '{6'h02, 2'h0, 4'h2, 4'h5, 32'h0, 8'h25, 1'b1, 1'b0, 4'h0},
    '{6'h01, 2'h0, 4'h0, 4'h0, 32'h0, 8'h2A, 1'b1, 1'b0, 4'h0},
    '{6'h01, 2'h0, 4'h0, 4'h0, 32'h0, 8'h34, 1'b1, 1'b0, 4'h0},
    '{6'h01, 2'h0, 4'h0, 4'h0, 32'h0, 8'h28, 1'b1, 1'b0, 4'h0},
    '{6'h01, 2'h0, 4'h0, 4'h0, 32'h0, 8'h00, 1'b1, 1'b0, 4'h0},
    '{6'h02, 2'h0, 4'h1, 4'h8, 32'h0, 8'h18, 1'b1, 1'b0, 4'h0},
    '{6'h01, 2'h0, 4'h0, 4'h0, 32'h0, 8'h00, 1'b1, 1'b0, 4'h0},
    '{6'h02, 2'h0, 4'h3, 4'h0, 32'h0, 8'h00, 1'b1, 1'b0, 4'h0},
    '{6'h04, 2'h0, 4'h5, 4'h0, 32'h0, 8'h50, 1'b1, 1'b0, 4'h0},
    '{6'h01, 2'h0, 4'h0, 4'h0, 32'h0, 8'h00, 1'b1, 1'b0, 4'h0},
    '{6'h04, 2'h0, 4'hF, 4'h0, 32'h0, 8'hF0, 1'b1, 1'b0, 4'h0},
    '{6'h20, 2'h2, 4'h0, 4'h0, 32'h0, 8'h00, 1'b1, 1'b0, 4'h0},
    '{6'h10, 2'h0, 4'h0, 4'h0, 32'h01005000, 8'h50, 1'b1, 1'b1, 4'h5},
    '{6'h00, 2'h0, 4'h0, 4'h0, 32'h0, 8'h50, 1'b1, 1'b0, 4'h0},
    '{6'h08, 2'h0, 4'h0, 4'h0, 32'h0, 8'h50, 1'b0, 1'b0, 4'h0},
    '{6'h08, 2'h1, 4'h0, 4'h0, 32'h0, 8'h50, 1'b1, 1'b0, 4'h0},
    '{6'h10, 2'h0, 4'h0, 4'h0, 32'h00001800, 8'h18, 1'b0, 1'b0, 4'h0},
    '{6'h20, 2'h2, 4'h0, 4'h0, 32'h0, 8'h00, 1'b1, 1'b0, 4'h0},
    '{6'h10, 2'h0, 4'h0, 4'h0, 32'hFFFFFFFF, 8'hFF, 1'b1, 1'b0, 4'h0},
    '{6'h20, 2'h0, 4'h0, 4'h0, 32'h0, 8'h00, 1'b0, 1'b0, 4'h0},
    '{6'h20, 2'h2, 4'h0, 4'h0, 32'h0, 8'h00, 1'b1, 1'b0, 4'h0},
    '{6'h36, 2'h2, 4'h3, 4'h8, 32'h00005000, 8'h00, 1'b1, 1'b0, 4'h0},
    '{6'h19, 2'h0, 4'h0, 4'h0, 32'h01005000, 8'h50, 1'b1, 1'b1, 4'h5},
    '{6'h06, 2'h0, 4'h2, 4'h8, 32'h0, 8'h20, 1'b1, 1'b0, 4'h0},
    '{6'h03, 2'h0, 4'h1, 4'h8, 32'h0, 8'h18, 1'b1, 1'b0, 4'h0},
    '{6'h01, 2'h0, 4'h0, 4'h0, 32'h0, 8'h00, 1'b1, 1'b0, 4'h0}
  };

  // ---------------------------------------------------------------------------
  // Design ports
  // ---------------------------------------------------------------------------
  logic        clk;               // 125 MHz clock.
  logic        reset_n;           // Active-low reset.
  logic        vector_load;       // Vector fetched.
  logic        vector_bit0;       // Bit 0 of the vector.
  logic        exc_return;        // Exception return.
  logic [31:0] stacked_word;      // Popped status word.
  logic        branch_exchange;   // Exchanging branch.
  logic        target_bit0;       // Bit 0 of the target.
  logic        transfer_suspend;  // Multiple transfer interrupted.
  logic [3:0]  next_reg_index;    // Next register operand.
  logic        cond_block_start;  // Block instruction decoded.
  logic [3:0]  block_first_cond;  // Base condition.
  logic [3:0]  block_mask;        // Block mask.
  logic        instr_retire;      // Instruction completed.
  logic        exec_attempt;      // Instruction about to execute.
  logic        in_fault_handler;  // Running a fault handler.
  logic        sw_rd_en;          // Software status read.
  logic [31:0] status_word;       // Execution-state bits.
  logic        cond_active;       // Block in progress.
  logic [3:0]  cond_code;         // Current condition.
  logic        resume_valid;      // Return into a suspended transfer.
  logic [3:0]  resume_index;      // Register to resume at.
  logic        fault_pulse;       // Wrong-state fault.
  logic        lockup;            // Sticky lockup.
  logic [31:0] sw_rd_data;        // Software read data.
  int          fails;             // Mismatches seen.
  int          check_count;       // Comparisons made.

  execution_state_status #(.INDEX_W(4)) dut (
    .clk(clk), .reset_n(reset_n), .vector_load(vector_load), .vector_bit0(vector_bit0),
    .exc_return(exc_return), .stacked_word(stacked_word), .branch_exchange(branch_exchange),
    .target_bit0(target_bit0), .transfer_suspend(transfer_suspend),
    .next_reg_index(next_reg_index), .cond_block_start(cond_block_start),
    .block_first_cond(block_first_cond), .block_mask(block_mask),
    .instr_retire(instr_retire), .exec_attempt(exec_attempt),
    .in_fault_handler(in_fault_handler), .sw_rd_en(sw_rd_en), .status_word(status_word),
    .cond_active(cond_active), .cond_code(cond_code), .resume_valid(resume_valid),
    .resume_index(resume_index), .fault_pulse(fault_pulse), .lockup(lockup),
    .sw_rd_data(sw_rd_data)
  );

  // ---------------------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------------------
  // Places the field and flag in a word; every other bit must read zero.
  function automatic logic [31:0] word_of(input logic [7:0] f, input logic flag);
    return {5'h00, f[1:0], flag, 8'h00, f[7:2], 10'h000};
  endfunction

  // Compares one value and reports a mismatch at once.
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Puts one row's strobes and data on the inputs.
  task automatic drive(input row_t r);
    {vector_load, exc_return, branch_exchange} = r.strb[5:3];
    {transfer_suspend, cond_block_start, instr_retire} = r.strb[2:0];
    {vector_bit0, target_bit0} = r.bit0s;
    next_reg_index = r.idx;
    block_first_cond = r.idx;
    block_mask = r.mask;
    stacked_word = r.stk;
  endtask

  // Prints the counts and the verdict, then ends the run.
  task automatic finish_test;
    $display("Checks %0d, failures %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // ---------------------------------------------------------------------------
  // Clock, watchdog and main sequence
  // ---------------------------------------------------------------------------
  // The clock toggles every half period of 4 ns.
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // The run needs well under a microsecond; a hang is cut off after 20 us.
  initial begin
    #20000;
    fails++;
    finish_test();
  end

  // Rows first, then software read, fault, lockup and a second reset.
  initial begin
    fails = 0;
    check_count = 0;
    drive('{default: '0});
    exec_attempt = 1'b0;
    in_fault_handler = 1'b0;
    sw_rd_en = 1'b0;
    reset_n = 1'b0;
    repeat (5) @(negedge clk);
    check(status_word, 32'h01000000);
    check({30'h0, fault_pulse, lockup}, 32'h0);
    reset_n = 1'b1;
    for (int i = 0; i < 26; i++) begin
      drive(rows[i]);
      @(negedge clk);
      check(status_word, word_of(rows[i].fld, rows[i].flag));
      check({31'h0, cond_active}, {31'h0, rows[i].fld[3:0] != 4'h0});
      if (rows[i].fld[3:0] != 4'h0) begin
        check({28'h0, cond_code}, {28'h0, rows[i].fld[7:4]});
      end
      check({31'h0, resume_valid}, {31'h0, rows[i].res});
      if (rows[i].res) begin
        check({28'h0, resume_index}, {28'h0, rows[i].ridx});
      end
    end
    drive('{strb: 6'h02, idx: 4'h1, mask: 4'h8, default: '0});
    sw_rd_en = 1'b1;
    @(negedge clk);
    check(sw_rd_data, 32'h0);
    drive('{strb: 6'h20, default: '0});
    sw_rd_en = 1'b0;
    @(negedge clk);
    drive('{default: '0});
    exec_attempt = 1'b1;
    @(negedge clk);
    exec_attempt = 1'b0;
    check({30'h0, fault_pulse, lockup}, 32'h2);
    @(negedge clk);
    check({31'h0, fault_pulse}, 32'h0);
    exec_attempt = 1'b1;
    in_fault_handler = 1'b1;
    @(negedge clk);
    drive('{strb: 6'h20, bit0s: 2'h2, default: '0});
    exec_attempt = 1'b0;
    in_fault_handler = 1'b0;
    check({31'h0, lockup}, 32'h1);
    @(negedge clk);
    drive('{default: '0});
    exec_attempt = 1'b1;
    repeat (3) @(negedge clk);
    check({30'h0, fault_pulse, lockup}, 32'h1);
    exec_attempt = 1'b0;
    reset_n = 1'b0;
    @(negedge clk);
    check(status_word, 32'h01000000);
    check({31'h0, lockup}, 32'h0);
    reset_n = 1'b1;
    @(negedge clk);
    check(status_word, 32'h01000000);
    drive('{strb: 6'h04, idx: 4'h9, default: '0});
    @(negedge clk);
    check(status_word, word_of(8'h90, 1'b1));
    finish_test();
  end
endmodule
